/* rtl/tbt_timing.sv */
`timescale 1ns/10ps
module tbt_timing (
  input  wire logic               clock_in,
  input  wire logic               srst_in,
  input  wire logic               wb_cyc_in,
  input  wire logic               wb_stb_in,
  input  wire logic               wb_we_in,
  input  wire logic [7:0]         wb_adr_in,
  input  wire logic [3:0]         wb_sel_in,
  input  wire logic [31:0]        wb_dat_in,
  output logic      [31:0]        wb_dat_out,
  output logic                    wb_ack_out,
  input  wire logic               call_req_in,
  input  wire logic               tx_end_in,
  input  wire logic               ack_rx_in,
  input  wire logic               ack_good_in,
  input  wire logic               rx_end_in,
  input  wire logic               rx_has_dsap_in,
  input  wire tbt_pkg::tbt_sap_t  rx_dsap_in,
  input  wire logic               token_rx_in,
  input  wire tbt_pkg::tbt_addr_t next_active_in,
  output logic                    call_go_out,
  output logic                    retry_out,
  output logic                    call_ok_out,
  output logic                    call_fail_out,
  output logic                    resp_ok_out,
  output logic                    rx_sap_valid_out,
  output tbt_pkg::tbt_sap_t       rx_sap_out,
  output logic                    token_late_out,
  output logic      [19:0]        hold_remain_out,
  output logic                    gap_poll_out,
  output tbt_pkg::tbt_addr_t      gap_first_out,
  output tbt_pkg::tbt_addr_t      gap_last_out
);
  import tbt_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Configuration registers

  tbt_rate_t   rate_q;
  tbt_addr_t   station_q;
  tbt_addr_t   hi_act_q;
  tbt_sap_t    sap_q;
  logic [3:0]  retry_q;
  logic [11:0] slot_q;
  logic [7:0]  setup_q;
  logic [7:0]  minta_q;
  logic [10:0] maxta_q;
  logic [19:0] rot_tgt_q;
  logic [6:0]  gap_q;
  logic        passive_q;
  logic        enable_q;

  logic        ack_q;
  logic [31:0] rdat_q;
  logic        wr_now;
  logic [31:0] cur;
  logic [31:0] wv;
  tbt_status_t status;

  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdat_q;
  // Write lands on the edge that sees ack high
  assign wr_now     = wb_cyc_in & wb_stb_in & wb_we_in & ack_q;

  always_comb begin
    if (wb_adr_in == OFS_RATE) begin
      cur = 32'(rate_q);
    end else if (wb_adr_in == OFS_STATION) begin
      cur = 32'(station_q);
    end else if (wb_adr_in == OFS_HI_ACT) begin
      cur = 32'(hi_act_q);
    end else if (wb_adr_in == OFS_SAP) begin
      cur = 32'(sap_q);
    end else if (wb_adr_in == OFS_RETRY) begin
      cur = 32'(retry_q);
    end else if (wb_adr_in == OFS_SLOT) begin
      cur = 32'(slot_q);
    end else if (wb_adr_in == OFS_SETUP) begin
      cur = 32'(setup_q);
    end else if (wb_adr_in == OFS_MINTA) begin
      cur = 32'(minta_q);
    end else if (wb_adr_in == OFS_MAXTA) begin
      cur = 32'(maxta_q);
    end else if (wb_adr_in == OFS_ROT_TGT) begin
      cur = 32'(rot_tgt_q);
    end else if (wb_adr_in == OFS_GAP) begin
      cur = 32'(gap_q);
    end else if (wb_adr_in == OFS_MODE) begin
      cur = {30'h0, enable_q, passive_q};
    end else if (wb_adr_in == OFS_STATUS) begin
      cur = status;
    end else begin
      cur = 32'h0;
    end
  end

  assign wv = merge(cur, wb_dat_in, wb_sel_in);

  // Bus handshake, one wait state
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q  <= wb_cyc_in & wb_stb_in & ~ack_q;
      rdat_q <= (wb_cyc_in & wb_stb_in & ~ack_q) ? cur : rdat_q;
    end
  end

  // R12: recommended defaults
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rate_q    <= RATE_RST;
      station_q <= STATION_RST;
      hi_act_q  <= HI_ACT_RST;
      sap_q     <= SAP_RST;
      retry_q   <= RETRY_RST;
      slot_q    <= SLOT_RST;
      setup_q   <= SETUP_RST;
      minta_q   <= MINTA_RST;
      maxta_q   <= MAXTA_RST;
      rot_tgt_q <= TGT_RST;
      gap_q     <= GAP_RST;
      passive_q <= 1'b0;
      enable_q  <= 1'b0;
    end else if (wr_now) begin
      // R2: only listed rates
      if (wb_adr_in == OFS_RATE) begin
        rate_q <= tbt_rate_t'(clamp(wv, 32'h0, RATE_MAX));
      end else if (wb_adr_in == OFS_STATION) begin
        station_q <= tbt_addr_t'(clamp(wv, 32'h0, ADDR_MAX));
      end else if (wb_adr_in == OFS_HI_ACT) begin
        hi_act_q <= tbt_addr_t'(clamp(wv, 32'h0, ADDR_MAX));
      end else if (wb_adr_in == OFS_SAP) begin
        sap_q <= tbt_sap_t'(clamp(wv, 32'h0, SAP_MAX));
      end else if (wb_adr_in == OFS_RETRY) begin
        // R4: retry range
        retry_q <= 4'(clamp(wv, RETRY_MIN, RETRY_MAX));
      end else if (wb_adr_in == OFS_SLOT) begin
        slot_q <= 12'(clamp(wv, SLOT_MIN, SLOT_MAX));
      end else if (wb_adr_in == OFS_SETUP) begin
        setup_q <= 8'(clamp(wv, SETUP_MIN, SETUP_MAX));
      end else if (wb_adr_in == OFS_MINTA) begin
        minta_q <= 8'(clamp(wv, MINTA_MIN, MINTA_MAX));
      end else if (wb_adr_in == OFS_MAXTA) begin
        maxta_q <= 11'(clamp(wv, MAXTA_MIN, MAXTA_MAX));
      end else if (wb_adr_in == OFS_ROT_TGT) begin
        rot_tgt_q <= 20'(clamp(wv, TGT_MIN, TGT_MAX));
      end else if (wb_adr_in == OFS_GAP) begin
        gap_q <= 7'(clamp(wv, GAP_MIN, GAP_MAX));
      end else if (wb_adr_in == OFS_MODE) begin
        passive_q <= wv[0];
        enable_q  <= wv[1];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Bit-time tick

  tbt_tick_if tk ();
  logic tick;

  assign tk.rate = rate_q;
  assign tick    = tk.tick;

  tbt_tick_gen u_tick (
    .clock_in (clock_in),
    .srst_in  (srst_in),
    .tk       (tk)
  );

  //////////////////////////////////////////////////////////////////////
  // Guard counters: since own transmit, since good ack, since receive

  localparam int G_TX  = 0;
  localparam int G_ACK = 1;
  localparam int G_RX  = 2;

  logic [2:0]  g_restart;
  logic [11:0] guard_q [3];

  assign g_restart = {rx_end_in, ack_rx_in & ack_good_in, tx_end_in};

  // R11: counted in bit times
  for (genvar g = 0; g < 3; g++) begin : g_guard
    always_ff @(posedge clock_in) begin
      if (srst_in) begin
        guard_q[g] <= GUARD_SAT;
      end else if (g_restart[g]) begin
        guard_q[g] <= '0;
      end else if (tick && guard_q[g] != GUARD_SAT) begin
        guard_q[g] <= guard_q[g] + 12'h1;
      end
    end
  end

  logic addr_ok;
  logic ready;

  // R1: address limits
  assign addr_ok = passive_q ? (32'(station_q) <= ADDR_MAX) : (station_q <= hi_act_q);
  // R6: setup dead time; R8: max turnaround after transmit
  assign ready = enable_q & addr_ok & ~passive_q
               & (guard_q[G_TX] >= 12'(maxta_q))
               & (guard_q[G_ACK] >= 12'(setup_q));
  // R7: responder holds off for minimum turnaround
  assign resp_ok_out = guard_q[G_RX] >= 12'(minta_q);

  //////////////////////////////////////////////////////////////////////
  // Call and retry sequencer

  tbt_state_t  state_q;
  logic [11:0] slot_cnt_q;
  logic [11:0] slot_eff;
  logic [3:0]  attempts_q;

  // R5: never below 2 ms
  assign slot_eff    = (slot_q > tbt_slot_floor(rate_q)) ? slot_q : tbt_slot_floor(rate_q);
  assign call_go_out = (state_q == ST_IDLE) & call_req_in & ready;

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state_q       <= ST_IDLE;
      slot_cnt_q    <= '0;
      attempts_q    <= '0;
      retry_out     <= 1'b0;
      call_ok_out   <= 1'b0;
      call_fail_out <= 1'b0;
    end else begin
      retry_out     <= 1'b0;
      call_ok_out   <= 1'b0;
      call_fail_out <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (call_go_out) begin
            state_q <= ST_TX;
          end
        end
        ST_TX: begin
          if (tx_end_in) begin
            state_q    <= ST_WAIT;
            slot_cnt_q <= '0;
          end
        end
        ST_WAIT: begin
          if (ack_rx_in && ack_good_in) begin
            state_q     <= ST_IDLE;
            attempts_q  <= '0;
            call_ok_out <= 1'b1;
          // R5: slot expiry
          end else if (slot_cnt_q >= slot_eff) begin
            state_q <= ST_IDLE;
            // R4: repeat up to limit
            if (attempts_q < retry_q) begin
              attempts_q <= attempts_q + 4'h1;
              retry_out  <= 1'b1;
            end else begin
              attempts_q    <= '0;
              call_fail_out <= 1'b1;
            end
          end else if (tick) begin
            slot_cnt_q <= slot_cnt_q + 12'h1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Received frame SAP steering

  // R3: default SAP
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rx_sap_valid_out <= 1'b0;
      rx_sap_out       <= '0;
    end else begin
      rx_sap_valid_out <= rx_end_in;
      if (rx_end_in) begin
        rx_sap_out <= rx_has_dsap_in ? rx_dsap_in : sap_q;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Token rotation

  logic [19:0] rot_q;

  // R9: rotation compare
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rot_q           <= '0;
      token_late_out  <= 1'b0;
      hold_remain_out <= '0;
    end else if (token_rx_in) begin
      rot_q           <= '0;
      token_late_out  <= rot_q >= rot_tgt_q;
      hold_remain_out <= (rot_q >= rot_tgt_q) ? 20'h0 : rot_tgt_q - rot_q;
    end else if (tick && rot_q != 20'(TGT_MAX)) begin
      rot_q <= rot_q + 20'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Gap polling

  logic [19:0] gap_bits_q;
  logic [6:0]  gap_per_q;
  logic        gap_due_q;
  logic        period_end;
  logic        gap_hit;

  assign period_end = tick & (gap_bits_q >= rot_tgt_q - 20'h1);
  assign gap_hit    = period_end & (gap_per_q >= gap_q - 7'h1);

  // R10: gap period of G times target rotation
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      gap_bits_q <= '0;
      gap_per_q  <= '0;
    end else if (period_end) begin
      gap_bits_q <= '0;
      gap_per_q  <= gap_hit ? 7'h0 : gap_per_q + 7'h1;
    end else if (tick) begin
      gap_bits_q <= gap_bits_q + 20'h1;
    end
  end

  // R10: poll on next token, new expiry wins over clear
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      gap_due_q     <= 1'b0;
      gap_poll_out  <= 1'b0;
      gap_first_out <= '0;
      gap_last_out  <= '0;
    end else begin
      gap_poll_out <= 1'b0;
      if (gap_hit) begin
        gap_due_q <= 1'b1;
      end else if (token_rx_in && gap_due_q && ready) begin
        gap_due_q <= 1'b0;
      end
      if (token_rx_in && gap_due_q && ready) begin
        gap_poll_out  <= 1'b1;
        gap_first_out <= station_q + 7'h1;
        gap_last_out  <= (next_active_in > station_q) ? next_active_in - 7'h1 : hi_act_q;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Status

  always_comb begin
    status             = '0;
    status.state       = 2'(state_q);
    status.attempts    = attempts_q;
    status.gap_periods = gap_per_q;
    status.gap_due     = gap_due_q;
    status.token_late  = token_late_out;
    status.addr_ok     = addr_ok;
  end

endmodule // tbt_timing

/* rtl/tbt_pkg.sv */
// Summary of operation
// R1: Active stations stay at or below highest active address; passive up to 126.
// R2: Bus data rate is one of 9.6, 19.2, 93.75, 187.5, 500, 1500 kbit/s.
// R3: Received frame without destination SAP goes to the default SAP.
// R4: Missing correct acknowledgement repeats the call, 1 to 8 times.
// R5: Initiator waits slot time, 80 to 4095 bits, at least 2 ms, then retries.
// R6: After an acknowledgement, idle at least setup time (1 to 255 bits) before calling.
// R7: Responder waits minimum turnaround, 0 to 255 bits, from last received bit.
// R8: After transmitting, wait maximum turnaround (1 to 1024 bits) before next call.
// R9: On token, compare elapsed rotation with target (3000 to 1048575) to allow sending.
// R10: Every gap factor times target rotation, poll free addresses up to next station.
// R11: All bus timing counts in bit times of the selected rate.
// R12: Defaults at 1500 kbit/s: slot 3000, setup 80, turnaround 150/980, gap 50.
// R13: Bit-time tick comes from a clock divider chosen by the data rate.
package tbt_pkg;

  localparam int CLK_HZ     = 250_000_000;
  localparam int N_RATES    = 6;
  localparam int MIN_SLOT_MS = 2;
  localparam int MS_PER_S   = 1000;
  localparam int RATE_BPS [N_RATES] = '{9600, 19200, 93750, 187500, 500000, 1500000};

  typedef logic [2:0]  tbt_rate_t;
  typedef logic [14:0] tbt_div_t;
  typedef logic [6:0]  tbt_addr_t;
  typedef logic [5:0]  tbt_sap_t;

  // Register byte offsets
  localparam logic [7:0] OFS_RATE    = 8'h00;
  localparam logic [7:0] OFS_STATION = 8'h04;
  localparam logic [7:0] OFS_HI_ACT  = 8'h08;
  localparam logic [7:0] OFS_SAP     = 8'h0c;
  localparam logic [7:0] OFS_RETRY   = 8'h10;
  localparam logic [7:0] OFS_SLOT    = 8'h14;
  localparam logic [7:0] OFS_SETUP   = 8'h18;
  localparam logic [7:0] OFS_MINTA   = 8'h1c;
  localparam logic [7:0] OFS_MAXTA   = 8'h20;
  localparam logic [7:0] OFS_ROT_TGT = 8'h24;
  localparam logic [7:0] OFS_GAP     = 8'h28;
  localparam logic [7:0] OFS_MODE    = 8'h2c;
  localparam logic [7:0] OFS_STATUS  = 8'h30;

  // Legal ranges, writes are clamped into them
  localparam logic [31:0] RATE_MAX  = 32'h5;
  localparam logic [31:0] ADDR_MAX  = 32'h7e;
  localparam logic [31:0] SAP_MAX   = 32'h3f;
  localparam logic [31:0] RETRY_MIN = 32'h1;
  localparam logic [31:0] RETRY_MAX = 32'h8;
  localparam logic [31:0] SLOT_MIN  = 32'h50;
  localparam logic [31:0] SLOT_MAX  = 32'hfff;
  localparam logic [31:0] SETUP_MIN = 32'h1;
  localparam logic [31:0] SETUP_MAX = 32'hff;
  localparam logic [31:0] MINTA_MIN = 32'h0;
  localparam logic [31:0] MINTA_MAX = 32'hff;
  localparam logic [31:0] MAXTA_MIN = 32'h1;
  localparam logic [31:0] MAXTA_MAX = 32'h400;
  localparam logic [31:0] TGT_MIN   = 32'hbb8;
  localparam logic [31:0] TGT_MAX   = 32'hfffff;
  localparam logic [31:0] GAP_MIN   = 32'h1;
  localparam logic [31:0] GAP_MAX   = 32'h64;

  // Reset values
  localparam tbt_rate_t   RATE_RST    = 3'h5;
  localparam tbt_addr_t   STATION_RST = 7'h00;
  localparam tbt_addr_t   HI_ACT_RST  = 7'h7e;
  localparam tbt_sap_t    SAP_RST     = 6'h00;
  localparam logic [3:0]  RETRY_RST   = 4'h1;
  localparam logic [11:0] SLOT_RST    = 12'hbb8;
  localparam logic [7:0]  SETUP_RST   = 8'h50;
  localparam logic [7:0]  MINTA_RST   = 8'h96;
  localparam logic [10:0] MAXTA_RST   = 11'h3d4;
  localparam logic [19:0] TGT_RST     = 20'h0c350;
  localparam logic [6:0]  GAP_RST     = 7'h32;

  localparam logic [11:0] GUARD_SAT = 12'hfff;

  typedef enum {ST_IDLE, ST_TX, ST_WAIT} tbt_state_t;

  typedef struct packed {
    logic [15:0] pad;
    logic [1:0]  state;
    logic [3:0]  attempts;
    logic [6:0]  gap_periods;
    logic        gap_due;
    logic        token_late;
    logic        addr_ok;
  } tbt_status_t;

  function automatic tbt_div_t tbt_rate_div(input tbt_rate_t sel);
    int d;
    d = (sel > tbt_rate_t'(RATE_MAX)) ? 1 : CLK_HZ / RATE_BPS[sel];
    return tbt_div_t'(d);
  endfunction

  function automatic logic [11:0] tbt_slot_floor(input tbt_rate_t sel);
    int b;
    b = (sel > tbt_rate_t'(RATE_MAX)) ? 0 : (RATE_BPS[sel] * MIN_SLOT_MS + MS_PER_S - 1) / MS_PER_S;
    return 12'(b);
  endfunction

endpackage

/* rtl/tbt_tick_if.sv */
`timescale 1ns/10ps
interface tbt_tick_if;
  tbt_pkg::tbt_rate_t rate;
  logic               tick;
  modport gen (input rate, output tick);
  modport sink (output rate, input tick);
endinterface

/* rtl/tbt_tick_gen.sv */
`timescale 1ns/10ps
module tbt_tick_gen (
  input  wire logic clock_in,
  input  wire logic srst_in,
  tbt_tick_if.gen   tk
);
  import tbt_pkg::*;

  tbt_div_t cnt_q;
  tbt_div_t div;
  logic     tick_q;

  assign div     = tbt_rate_div(tk.rate);
  assign tk.tick = tick_q;

  // R13: rate divider
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (cnt_q >= div - tbt_div_t'(1)) begin
      cnt_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + tbt_div_t'(1);
      tick_q <= 1'b0;
    end
  end

endmodule // tbt_tick_gen

/* verification/tbt_timing_monitor.sv */
`timescale 1ns/10ps
module tbt_timing_monitor (
  input wire logic              clock_in,
  input wire logic              srst_in,
  input wire logic              wb_cyc_in,
  input wire logic              wb_stb_in,
  input wire logic              wb_ack_out,
  input wire logic              call_req_in,
  input wire logic              ack_rx_in,
  input wire logic              ack_good_in,
  input wire logic              rx_end_in,
  input wire logic              rx_has_dsap_in,
  input wire tbt_pkg::tbt_sap_t rx_dsap_in,
  input wire logic              token_rx_in,
  input wire logic              call_go_out,
  input wire logic              retry_out,
  input wire logic              call_ok_out,
  input wire logic              call_fail_out,
  input wire logic              rx_sap_valid_out,
  input wire tbt_pkg::tbt_sap_t rx_sap_out,
  input wire logic              token_late_out,
  input wire logic [19:0]       hold_remain_out,
  input wire logic              gap_poll_out
);
  import tbt_pkg::*;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);

  AST_WB_ACK: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("bus ack late");
  AST_WB_PULSE: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("bus ack too long");
  AST_GO_REQ: assert property (call_go_out |-> call_req_in)
    else $error("call start without request");
  AST_SETUP_HOLD: assert property (call_ok_out |-> !call_go_out)
    else $error("call start inside setup time");
  AST_GO_HOLD: assert property (call_go_out |=> !call_go_out [*8])
    else $error("call start repeated");
  AST_OK_CAUSE: assert property (call_ok_out |-> $past(ack_rx_in && ack_good_in))
    else $error("call done without good ack");
  AST_END_ONE: assert property ($onehot0({retry_out, call_ok_out, call_fail_out}))
    else $error("call outcomes overlap");
  AST_SAP_DSAP: assert property (rx_end_in && rx_has_dsap_in |=> rx_sap_valid_out && rx_sap_out == $past(rx_dsap_in))
    else $error("sap not taken from frame");
  AST_SAP_CAUSE: assert property (rx_sap_valid_out |-> $past(rx_end_in))
    else $error("sap valid without frame");
  AST_TOKEN_CMP: assert property (token_rx_in |=> token_late_out == (hold_remain_out == 20'h0))
    else $error("late flag and hold time disagree");
  AST_GAP_CAUSE: assert property (gap_poll_out |-> $past(token_rx_in))
    else $error("gap poll without token");
  COV_OK: cover property (call_ok_out);
  COV_SAP: cover property (rx_sap_valid_out);
  COV_TOKEN: cover property (token_rx_in ##1 !token_late_out);
endmodule // tbt_timing_monitor

bind tbt_timing tbt_timing_monitor i_mon (
  .clock_in, .srst_in, .wb_cyc_in, .wb_stb_in, .wb_ack_out, .call_req_in, .ack_rx_in, .ack_good_in,
  .rx_end_in, .rx_has_dsap_in, .rx_dsap_in, .token_rx_in, .call_go_out, .retry_out, .call_ok_out,
  .call_fail_out, .rx_sap_valid_out, .rx_sap_out, .token_late_out, .hold_remain_out, .gap_poll_out
);

/* verification/tbt_station_model.sv */
`timescale 1ns/10ps
module tbt_station_model #(
  parameter int TX_CLK = 200,
  parameter int TA_CLK = 600
) (
  input  wire logic clock_in,
  input  wire logic srst_in,
  input  wire logic call_go_in,
  output logic      tx_end_out,
  output logic      ack_rx_out,
  output logic      ack_good_out
);
  initial begin
    tx_end_out = 1'b0;
    ack_rx_out = 1'b0;
    ack_good_out = 1'b0;
    forever begin
      @(posedge clock_in);
      if (call_go_in === 1'b1 && srst_in === 1'b0) begin
        repeat (TX_CLK) @(posedge clock_in);
        tx_end_out <= 1'b1;
        @(posedge clock_in);
        tx_end_out <= 1'b0;
        repeat (TA_CLK) @(posedge clock_in);
        ack_rx_out <= 1'b1;
        ack_good_out <= 1'b1;
        @(posedge clock_in);
        ack_rx_out <= 1'b0;
        ack_good_out <= 1'b0;
      end
    end
  end
endmodule // tbt_station_model

/* verification/tbt_timing_bench.sv */
`timescale 1ns/10ps
module tbt_timing_bench;
  import tbt_pkg::*;
  // Clocks per bit at 1.5 Mbit/s
  localparam int BIT  = 166;
  localparam int TAC  = 600;
  localparam int CEIL = 60000;
  logic        clock_in, srst_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out, call_req_in;
  logic        tx_end_in, ack_rx_in, ack_good_in, rx_end_in, rx_has_dsap_in, token_rx_in;
  logic        call_go_out, retry_out, call_ok_out, call_fail_out, resp_ok_out;
  logic        rx_sap_valid_out, token_late_out, gap_poll_out;
  logic [7:0]  wb_adr_in;
  logic [31:0] wb_dat_in, wb_dat_out, rd;
  logic [19:0] hold_remain_out;
  tbt_sap_t    rx_dsap_in, rx_sap_out;
  tbt_addr_t   gap_first_out, gap_last_out;
  int          n_fail, checks_done, cycles, n;
  logic [7:0]  ta [24] = '{OFS_RATE, OFS_HI_ACT, OFS_RETRY, OFS_SLOT, OFS_SETUP, OFS_MINTA, OFS_MAXTA, OFS_GAP,
    OFS_STATION, OFS_STATUS, OFS_RATE, OFS_HI_ACT, OFS_RETRY, OFS_RETRY, OFS_SLOT, OFS_SETUP, OFS_MAXTA,
    OFS_ROT_TGT, OFS_ROT_TGT, OFS_GAP, OFS_GAP, OFS_STATION, OFS_STATUS, 8'h3c};
  logic [31:0] tw [14] = '{32'h7, 32'h7f, 32'h0, 32'h9, 32'h10, 32'h0, 32'h401, 32'h100, 32'h100000,
    32'h65, 32'h0, 32'h7f, 32'hffff, 32'h5a};
  logic [31:0] te [24] = '{32'h5, 32'h7e, 32'h1, 32'hbb8, 32'h50, 32'h96, 32'h3d4, 32'h32, 32'h0, 32'h1,
    32'h5, 32'h7e, 32'h1, 32'h8, 32'h50, 32'h1, 32'h400, 32'hbb8, 32'hfffff, 32'h64, 32'h1, 32'h7e,
    32'h1, 32'h0};

  tbt_timing i_dut (
    .clock_in, .srst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in(4'hf), .wb_dat_in,
    .wb_dat_out, .wb_ack_out, .call_req_in, .tx_end_in, .ack_rx_in, .ack_good_in, .rx_end_in,
    .rx_has_dsap_in, .rx_dsap_in, .token_rx_in, .next_active_in(7'h10), .call_go_out, .retry_out,
    .call_ok_out, .call_fail_out, .resp_ok_out, .rx_sap_valid_out, .rx_sap_out, .token_late_out,
    .hold_remain_out, .gap_poll_out, .gap_first_out, .gap_last_out
  );
  tbt_station_model #(.TX_CLK(200), .TA_CLK(TAC)) i_peer (
    .clock_in, .srst_in, .call_go_in(call_go_out), .tx_end_out(tx_end_in), .ack_rx_out(ack_rx_in),
    .ack_good_out(ack_good_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_val(input string s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic chk_rng(input string s, input int lo, input int hi, input logic [31:0] g);
    checks_done++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      n_fail++;
      $display("ERROR %s expected %0d..%0d seen %0d", s, lo, hi, g);
    end
  endtask

  task automatic wb_io(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= w;
    wb_adr_in <= a;
    wb_dat_in <= d;
    do @(posedge clock_in); while (wb_ack_out !== 1'b1);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in <= 1'b0;
  endtask

  task automatic rx_frame(input logic hd, input tbt_sap_t ds);
    @(posedge clock_in);
    rx_end_in <= 1'b1;
    rx_has_dsap_in <= hd;
    rx_dsap_in <= ds;
    @(posedge clock_in);
    rx_end_in <= 1'b0;
    #1;
  endtask

  task automatic pulse_token();
    @(posedge clock_in);
    token_rx_in <= 1'b1;
    @(posedge clock_in);
    token_rx_in <= 1'b0;
    #1;
  endtask

  task automatic wait_ok();
    do @(posedge clock_in); while (call_ok_out !== 1'b1);
  endtask

  task automatic go_count(input int c);
    n = 0;
    repeat (c) begin
      @(posedge clock_in);
      if (call_go_out === 1'b1) n++;
    end
  endtask

  // Spacing from a good ack to the next call start
  task automatic call_gap(input int su, input int tm);
    int e;
    wb_io(1'b1, OFS_SETUP, 32'(su));
    wb_io(1'b1, OFS_MAXTA, 32'(tm));
    call_req_in <= 1'b1;
    wait_ok();
    call_req_in <= 1'b0;
    @(posedge clock_in);
    call_req_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (call_go_out !== 1'b1);
    e = (su * BIT > tm * BIT - TAC) ? su * BIT : tm * BIT - TAC;
    chk_rng("call_spacing", e - BIT - 8, e + BIT + 8, n);
    wait_ok();
    call_req_in <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == CEIL) begin
      n_fail++;
      stop_test();
    end
  end

  initial begin
    {srst_in, wb_cyc_in, wb_stb_in, wb_we_in, call_req_in, rx_end_in, rx_has_dsap_in, token_rx_in} = 8'h80;
    wb_adr_in = 8'h00;
    wb_dat_in = 32'h0;
    rx_dsap_in = 6'h00;
    n_fail = 0;
    checks_done = 0;
    cycles = 0;
    repeat (20) @(posedge clock_in);
    srst_in <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      if (i > 9) wb_io(1'b1, ta[i], tw[i - 10]);
      wb_io(1'b0, ta[i], 32'h0);
      chk_val($sformatf("reg_%h", ta[i]), te[i], rd);
    end
    for (int r = 0; r < 6; r++) begin
      wb_io(1'b1, OFS_RATE, 32'(r));
      wb_io(1'b0, OFS_RATE, 32'h0);
      chk_val("rate", 32'(r), rd);
    end
    wb_io(1'b1, OFS_SAP, 32'h15);
    wb_io(1'b1, OFS_MINTA, 32'h3);
    rx_frame(1'b0, 6'h22);
    chk_val("sap_default", 32'h15, 32'(rx_sap_out));
    chk_val("resp_early", 32'h0, 32'(resp_ok_out));
    repeat (5 * BIT) @(posedge clock_in);
    #1;
    chk_val("resp_late", 32'h1, 32'(resp_ok_out));
    rx_frame(1'b1, 6'h22);
    chk_val("sap_frame", 32'h22, 32'(rx_sap_out));
    wb_io(1'b1, OFS_ROT_TGT, 32'hbb8);
    pulse_token();
    repeat (10 * BIT) @(posedge clock_in);
    pulse_token();
    chk_val("token_late", 32'h0, 32'(token_late_out));
    chk_rng("hold_remain", 2988, 2992, hold_remain_out);
    wb_io(1'b1, OFS_MODE, 32'h2);
    wb_io(1'b1, OFS_STATION, 32'h1);
    call_gap(10, 30);
    call_gap(40, 5);
    wb_io(1'b1, OFS_MODE, 32'h3);
    wb_io(1'b1, OFS_STATION, 32'h10);
    wb_io(1'b1, OFS_HI_ACT, 32'h5);
    call_req_in <= 1'b1;
    go_count(8000);
    chk_val("passive_go", 32'h0, n);
    wb_io(1'b1, OFS_MODE, 32'h2);
    go_count(500);
    chk_val("high_addr_go", 32'h0, n);
    wb_io(1'b1, OFS_HI_ACT, 32'h7e);
    wait_ok();
    call_req_in <= 1'b0;
    stop_test();
  end
endmodule // tbt_timing_bench
